// ### common/pad_mux_pkg.sv
package pad_mux_pkg;

	// ==========================================================
	// Register map (APB, one aligned word per register)
	// ==========================================================
	localparam int num_pads = 8;
	localparam int num_shared = 2;
	localparam logic [11:0] pad_cfg_base = 12'h000;
	localparam logic [11:0] src_mux_off = 12'h100;
	localparam logic [11:0] standby_off = 12'h104;
	localparam logic [11:0] pad_state_off = 12'h108;

	// ==========================================================
	// Field layout of pad_config_reg
	// ==========================================================
	localparam int alt_sel_lsb = 0;
	localparam int ibe_bit = 2;
	localparam int nmi_bit = 3;
	localparam logic [1:0] alt_gpio = 2'h0;
	localparam logic [3:0] cfg_reset_gpio = 4'h0;
	// Test port pads come up with input buffer on, test function as alt 2
	localparam logic [3:0] cfg_reset_test = 4'h6;

	// Pad indices of the test port pads
	localparam int tdi_pad = 0;
	localparam int tdo_pad = 1;
	localparam int tck_pad = 2;
	localparam int tms_pad = 3;
	localparam logic [1:0] alt_test = 2'h2;

	typedef struct packed {
		logic nmi_sel;
		logic input_buffer_en;
		logic [1:0] alt_select;
	} pad_cfg_t;

	typedef struct packed {
		logic [3:0] func_out;
		logic [3:0] func_oe;
	} pad_func_t;

endpackage : pad_mux_pkg

// ### hdl/pad_function_select.sv
`timescale 1ns/1ps

// Functional notes
// - Each pad's output comes from function 0..3 chosen by its alt_select.
// - A pad's input reaches modules only when its input_buffer_en is 1 or it is TDO in standby; the nmi ignores input_buffer_en.
// - Each pad input fans out to all modules that use it, unselected.
// - Shared module inputs take the pad named by their pad_select field.
// - A pad with nmi selected feeds the nmi with its output enable off; alt_field still picks pad_out.
// - After reset all pads are general-purpose except the test port pads.
// - After reset pads 0,1 carry TDI,TDO and pads 2,3 carry TCK,TMS.
// - In standby the TDO pad is an input, powered, with no pull resistor.
// - Every wakeup pad input also drives an external interrupt line.
module pad_function_select #(
	parameter int pads = pad_mux_pkg::num_pads
) (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire pad_mux_pkg::pad_func_t func [pads],
	input wire logic [pads-1:0] pad_in,
	output logic [pads-1:0] pad_out,
	output logic [pads-1:0] pad_oe_n,
	output logic [pads-1:0] pad_pull_en,
	output logic [pads-1:0] module_in,
	output logic [pads-1:0] external_irq_line,
	output logic [pad_mux_pkg::num_shared-1:0] shared_in,
	output logic nmi_in,
	output logic standby_mode
);
	import pad_mux_pkg::*;

	// ==========================================================
	// Registers
	// ==========================================================
	pad_cfg_t cfg [pads];
	logic [2*num_shared-1:0] input_source_mux;
	logic [pads-1:0] pin_meta;
	logic [pads-1:0] pin_sync;

	// The four test port pads, whatever their indices
	function automatic logic is_test_pad(input int idx);
		return idx == tdi_pad || idx == tdo_pad || idx == tck_pad
			|| idx == tms_pad;
	endfunction : is_test_pad

	function automatic logic [3:0] reset_cfg(input int idx);
		if (is_test_pad(idx))
			return cfg_reset_test;
		return cfg_reset_gpio;
	endfunction : reset_cfg

	// Field positions come from the package so software and logic agree
	function automatic pad_cfg_t unpack_cfg(input logic [31:0] d);
		pad_cfg_t c;
		c.alt_select = d[alt_sel_lsb +: 2];
		c.input_buffer_en = d[ibe_bit];
		c.nmi_sel = d[nmi_bit];
		return c;
	endfunction : unpack_cfg

	function automatic logic [31:0] pack_cfg(input pad_cfg_t c);
		logic [31:0] d;
		d = 32'h0;
		d[alt_sel_lsb +: 2] = c.alt_select;
		d[ibe_bit] = c.input_buffer_en;
		d[nmi_bit] = c.nmi_sel;
		return d;
	endfunction : pack_cfg

	// ==========================================================
	// APB decode
	// ==========================================================
	wire access = psel && penable;
	wire wr = access && pwrite;
	// Offset from the config base; below the base it wraps and misses
	wire [11:0] cfg_rel = paddr - pad_cfg_base;
	wire [9:0] word = cfg_rel[11:2];
	wire cfg_hit = cfg_rel < 12'(pads * 4);
	wire src_hit = paddr == src_mux_off;
	wire stb_hit = paddr == standby_off;
	wire st_hit = paddr == pad_state_off;
	wire mapped = cfg_hit || src_hit || stb_hit || st_hit;
	logic [31:0] rd_mux;

	// Unmapped reads return zero
	always_comb begin
		rd_mux = 32'h0;
		if (cfg_hit)
			rd_mux = pack_cfg(cfg[word[$clog2(pads)-1:0]]);
		else if (src_hit)
			rd_mux = 32'(input_source_mux);
		else if (stb_hit)
			rd_mux = {31'h0, standby_mode};
		else if (st_hit)
			rd_mux = 32'(pin_sync);
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0;
		end else begin
			// Answer at the edge that ends setup: no wait states
			pready <= psel && !pready;
			pslverr <= psel && !pready && !mapped;
			prdata <= rd_mux;
		end
	end

	wire take = wr && pready;
	wire src_take = take && src_hit;
	wire stb_take = take && stb_hit;

	// One config register per pad
	genvar g;
	generate
		for (g = 0; g < pads; g++) begin : cfg_regs
			always_ff @(posedge core_clk) begin
				if (reset)
					cfg[g] <= pad_cfg_t'(reset_cfg(g));
				else if (take && cfg_hit && word == 10'(g))
					cfg[g] <= unpack_cfg(pwdata);
			end
		end
	endgenerate

	// Shared inputs keep their pad choice until software rewrites it
	always_ff @(posedge core_clk) begin
		if (reset) begin
			input_source_mux <= '0;
			standby_mode <= 1'b0;
		end else begin
			if (src_take)
				input_source_mux <= pwdata[2*num_shared-1:0];
			if (stb_take)
				standby_mode <= pwdata[0];
		end
	end

	// ==========================================================
	// Pad side
	// ==========================================================
	// Two stages keep a metastable pad level away from the logic
	always_ff @(posedge core_clk) begin
		if (reset) begin
			pin_meta <= '0;
			pin_sync <= '0;
		end else begin
			pin_meta <= pad_in;
			pin_sync <= pin_meta;
		end
	end

	logic [pads-1:0] next_out;
	logic [pads-1:0] next_oe_n;
	logic [pads-1:0] next_pull;
	logic [pads-1:0] next_in;
	logic [pads-1:0] nmi_hits;

	generate
		for (g = 0; g < pads; g++) begin : pad_mux
			wire [1:0] sel = cfg[g].alt_select;
			wire nmi = cfg[g].nmi_sel;
			wire tdo_standby = (g == tdo_pad) && standby_mode;
			// NMI pad is input only: output enable forced off, pad_out still follows alt_field
			assign next_out[g] = func[g].func_out[sel];
			assign next_oe_n[g] = !(func[g].func_oe[sel] && !nmi
				&& !tdo_standby);
			// Pull kept off on TDO in standby; debugger drives it
			assign next_pull[g] = is_test_pad(g) && !tdo_standby;
			assign next_in[g] = pin_sync[g]
				&& (cfg[g].input_buffer_en || tdo_standby);
			assign nmi_hits[g] = nmi && pin_sync[g];
		end
	endgenerate

	logic [num_shared-1:0] next_shared;
	generate
		for (g = 0; g < num_shared; g++) begin : src_sel
			wire [1:0] ps = input_source_mux[2*g +: 2];
			assign next_shared[g] = next_in[ps];
		end
	endgenerate

	// ==========================================================
	// Output registers
	// ==========================================================
	// Every output leaves from a flop, so pads never see decode glitches
	always_ff @(posedge core_clk) begin
		if (reset) begin
			pad_out <= '0;
			pad_oe_n <= '1;
			pad_pull_en <= '0;
		end else begin
			pad_out <= next_out;
			pad_oe_n <= next_oe_n;
			pad_pull_en <= next_pull;
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			module_in <= '0;
			external_irq_line <= '0;
			shared_in <= '0;
			nmi_in <= 1'b0;
		end else begin
			module_in <= next_in;
			external_irq_line <= next_in;
			shared_in <= next_shared;
			nmi_in <= |nmi_hits;
		end
	end

endmodule : pad_function_select

// ### testbench/pad_fn_chk.sv
`timescale 1ns/1ps
module pad_fn_chk #(parameter int pads = 8) (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	input wire pad_mux_pkg::pad_func_t func [pads],
	input wire logic [pads-1:0] pad_out,
	input wire logic [pads-1:0] pad_oe_n,
	input wire logic [pads-1:0] pad_pull_en,
	input wire logic [pads-1:0] module_in,
	input wire logic [pads-1:0] external_irq_line,
	input wire logic nmi_in,
	input wire logic standby_mode
);
	import pad_mux_pkg::*;
	// ==========
	// Port relations
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);
	ack_pulse_a: assert property (pready |=> !pready) else $error("ack");
	ack_cause_a: assert property (pready |-> $past(psel && !penable))
		else $error("ack cause");
	err_ack_a: assert property (pslverr |-> pready) else $error("err");
	irq_copy_a: assert property (external_irq_line == module_in)
		else $error("irq");
	tdo_standby_a: assert property (standby_mode && $past(standby_mode)
		|-> !pad_pull_en[tdo_pad] && pad_oe_n[tdo_pad]) else $error("tdo");
	drive_cause_a: assert property (!pad_oe_n[0]
		|-> $past(func[0].func_oe) != 4'h0) else $error("drive");
	out_cause_a: assert property (pad_out[0]
		|-> $past(func[0].func_out) != 4'h0) else $error("out");
	reset_idle_a: assert property (disable iff (1'b0) reset ##1 reset
		|=> &pad_oe_n && !pready && !nmi_in) else $error("idle");
	cover property (pslverr);
	cover property (nmi_in);
	cover property (standby_mode ##2 standby_mode);
endmodule : pad_fn_chk
bind pad_function_select pad_fn_chk #(.pads(pads)) u_chk (.core_clk,
	.reset, .psel, .penable, .pready, .pslverr, .func, .pad_out,
	.pad_oe_n, .pad_pull_en, .module_in, .external_irq_line, .nmi_in,
	.standby_mode);

// ### testbench/pad_fn_peer.sv
`timescale 1ns/1ps
module pad_fn_peer (
	output pad_mux_pkg::pad_func_t func [8]
);
	import pad_mux_pkg::*;
	// Distinct pattern per pad, so a wrong selection shows
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			func[i] = {4'ha ^ 4'(i), 4'h6};
		end
	end
endmodule : pad_fn_peer

// ### testbench/pad_function_select_tb.sv
`timescale 1ns/1ps
module pad_function_select_tb;
	import pad_mux_pkg::*;
	logic core_clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0, prdata, rs = 32'h3bc5;
	logic pready, pslverr, nmi_in, standby_mode;
	logic [7:0] pad_in = 8'h0, pad_out, pad_oe_n, pull, module_in, irq;
	logic [1:0] shared_in;
	pad_func_t func [8];
	logic [32:0] q[$];
	int err_total = 0, n_checks = 0, cyc = 0;
	initial forever #2.5 core_clk = ~core_clk;
	pad_fn_peer u_peer (.func);
	pad_function_select u_dut (.core_clk, .reset, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .func,
		.pad_in, .pad_out, .pad_oe_n, .pad_pull_en(pull), .module_in,
		.external_irq_line(irq), .shared_in, .nmi_in, .standby_mode);
	function automatic logic [31:0] xs(input logic [31:0] v);
		v ^= v << 13;
		v ^= v >> 17;
		v ^= v << 5;
		return v;
	endfunction : xs
	task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("wrong value at %0t: %h not %h", $time, seen, exp);
		end
	endtask : chk
	task automatic summarize;
		$display("checks %0d, errors %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : summarize
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
	endtask : tick
	// Holds the request until pready is sampled high
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d, input logic [32:0] e);
		q.push_back(e);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1;
		do @(posedge core_clk); while (pready !== 1'b1);
		psel <= 0;
		penable <= 0;
		@(posedge core_clk);
	endtask : apb
	always @(posedge core_clk) begin
		cyc++;
		if (psel && penable && pready)
			chk({pslverr, pwrite ? 32'h0 : prdata}, q.pop_front());
		if (cyc == 2000) begin
			err_total++;
			summarize();
		end
	end
	localparam logic [3:0] e_out = 4'he;
	localparam logic [3:0] e_oe = 4'h6;
	initial begin
		tick(4);
		reset <= 0;
		tick(2);
		for (int i = 0; i < 5; i++) apb(0, 12'(4 * i), 0, (i < 4) ? 6 : 0);
		chk(33'(pull), 33'h0f);
		apb(0, 12'h200, 0, 33'h100000000);
		apb(1, 12'h204, 32'h5, 33'h100000000);
		for (int k = 0; k < 4; k++) begin
			apb(1, 12'h010, k, 0);
			tick(2);
			chk(33'({pad_out[4], pad_oe_n[4]}), 33'({e_out[k], ~e_oe[k]}));
		end
		rs = xs(rs);
		pad_in <= rs[7:0] | 8'h30;
		tick(5);
		chk(33'(module_in[4]), 33'h0);
		apb(0, 12'h108, 0, 33'(rs[7:0] | 8'h30));
		apb(1, 12'h010, 32'h4, 0);
		tick(2);
		chk(33'({module_in[4], irq[4]}), 33'h3);
		apb(1, 12'h014, 32'h9, 0);
		tick(2);
		chk(33'({nmi_in, pad_oe_n[5]}), 33'h3);
		chk(33'(module_in[3:0]), 33'(rs[3:0]));
		// Pads 6 and 7 stand in for the slow oscillator pins: ibe stays 0
		chk(33'(irq[7:6] | module_in[7:6]), 33'h0);
		apb(1, src_mux_off, 32'hd, 0);
		apb(0, src_mux_off, 0, 33'hd);
		chk(33'(shared_in), 33'({rs[3], rs[1]}));
		apb(1, 12'h00c, 32'h4, 0);
		tick(2);
		chk(33'({pad_out[3], pad_oe_n[3]}), 33'h3);
		apb(1, standby_off, 32'h1, 0);
		apb(0, standby_off, 0, 33'h1);
		tick(2);
		chk(33'({pull[1], pad_oe_n[1], standby_mode}), 33'h3);
		reset <= 1;
		tick(2);
		reset <= 0;
		tick(2);
		chk(33'({standby_mode, nmi_in, pull}), 33'h00f);
		apb(0, 12'h00c, 0, 33'(cfg_reset_test));
		apb(0, 12'h014, 0, 0);
		summarize();
	end
endmodule : pad_function_select_tb
